// *** core/csd_pkg.sv ***
// package for the external chip select decoder
// assumes a 24-bit external address and eight select outputs
package csd_pkg;

  localparam int unsigned ADDR_W    = 24;
  localparam int unsigned NUM_SEL   = 8;
  localparam int unsigned CODE_W    = 2;

  // window table: base and last address per output and area code
  typedef struct packed {
    logic        valid;
    logic [23:0] lo;
    logic [23:0] hi;
  } csd_win_t;

  localparam logic [7:0] SEL_RESET = 8'hff;
  localparam logic [1:0] CODE_RESET = 2'h0;

  // ***************************************************************
  // window lookup
  // ***************************************************************
  function automatic csd_win_t csd_window(input logic [2:0] sel, input logic [1:0] code);
    csd_win_t w;
    w = '{valid: 1'b1, lo: 24'h000000, hi: 24'h000000};
    case ({sel, code})
      5'h00: begin w.lo = 24'hf00000; w.hi = 24'hffffff; end
      5'h01: begin w.lo = 24'hf80000; w.hi = 24'hffffff; end
      5'h02: begin w.lo = 24'hfe0000; w.hi = 24'hffffff; end
      5'h04: begin w.lo = 24'he00000; w.hi = 24'hffffff; end
      5'h05: begin w.lo = 24'hf00000; w.hi = 24'hf7ffff; end
      5'h06: begin w.lo = 24'hfc0000; w.hi = 24'hfdffff; end
      5'h07: begin w.lo = 24'h68ff80; w.hi = 24'h68ffff; end
      5'h08: begin w.lo = 24'h003000; w.hi = 24'h003fff; end
      5'h09: begin w.lo = 24'hfa0000; w.hi = 24'hfbffff; end
      5'h0a: begin w.lo = 24'h68ff80; w.hi = 24'h68ffff; end
      5'h0b: begin w.lo = 24'h68ff00; w.hi = 24'h68ff7f; end
      5'h0c: begin w.lo = 24'hf80000; w.hi = 24'hf9ffff; end
      5'h0d: begin w.lo = 24'h68ff00; w.hi = 24'h68ff7f; end
      5'h0e: begin w.lo = 24'h68fe80; w.hi = 24'h68feff; end
      5'h0f: begin w.lo = 24'h0000c0; w.hi = 24'h0000ff; end
      5'h10: begin w.lo = 24'h002800; w.hi = 24'h002fff; end
      5'h11: begin w.lo = 24'h68fe80; w.hi = 24'h68feff; end
      5'h12: begin w.lo = 24'h0000c0; w.hi = 24'h0000ff; end
      5'h13: begin w.lo = 24'h0000e0; w.hi = 24'h0000ff; end
      5'h14: begin w.lo = 24'h68ff80; w.hi = 24'h68ffff; end
      5'h15: begin w.lo = 24'h0000c0; w.hi = 24'h0000ff; end
      5'h16: begin w.lo = 24'h0000e0; w.hi = 24'h0000ff; end
      5'h17: begin w.lo = 24'h0000d8; w.hi = 24'h0000df; end
      5'h18: begin w.lo = 24'h68ff00; w.hi = 24'h68ff7f; end
      5'h19: begin w.lo = 24'h0000c0; w.hi = 24'h0000ff; end
      5'h1a: begin w.lo = 24'h0000e0; w.hi = 24'h0000ff; end
      5'h1b: begin w.lo = 24'h0000d0; w.hi = 24'h0000d7; end
      5'h1c: begin w.lo = 24'h0000c0; w.hi = 24'h0000ff; end
      5'h1d: begin w.lo = 24'h0000e0; w.hi = 24'h0000ff; end
      5'h1e: begin w.lo = 24'h0000c8; w.hi = 24'h0000cf; end
      default: w.valid = 1'b0;
    endcase
    return w;
  endfunction

endpackage

// *** core/csd_if.sv ***
// interface carrying the access address between the decoder modules
// assumes one clock domain
`timescale 1ns/1ps
interface csd_if;
  logic [23:0] addr;
  logic        strobe;
  logic [15:0] codes;
  logic [7:0]  hit;
  modport top  (output addr, output strobe, output codes, input hit);
  modport cmp  (input addr, input strobe, input codes, output hit);
endinterface

// *** core/csd_cmp.sv ***
// window comparator for all eight select outputs
// assumes the caller registers the hit vector
`timescale 1ns/1ps
module csd_cmp
  import csd_pkg::*;
(
  csd_if.cmp bus
);

  always_comb
  begin
    csd_win_t w;
    w = '{valid: 1'b0, lo: 24'h000000, hi: 24'h000000};
    for (int i = 0; i < 8; i++)
    begin
      w = csd_window(3'(i), bus.codes[2*i +: 2]);
      // reserved code leaves the output idle
      bus.hit[i] = bus.strobe && w.valid && (bus.addr >= w.lo) && (bus.addr <= w.hi);
    end
  end

endmodule

// *** core/csd_top.sv ***
// external chip select decoder top
// assumes address and strobe come from bus logic on ref_clk_i
// ***************************************************************
// Notes on behaviour
// - eight select outputs, each own two-bit code
// - select active when address in chosen window
// - output zero windows: ROM and vector area
// - output one windows per area code
// - output two windows per area code
// - output three windows per area code
// - outputs four and five windows per code
// - outputs six and seven windows, seven reserved
// ***************************************************************
`timescale 1ns/1ps
module csd_top
  import csd_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic [23:0] access_addr_i,
  input  wire logic        access_valid_i,
  input  wire logic [15:0] area_select_code_i,
  output logic             select_out_zero_n_o,
  output logic             select_out_one_n_o,
  output logic             select_out_two_n_o,
  output logic             select_out_three_n_o,
  output logic             select_out_four_n_o,
  output logic             select_out_five_n_o,
  output logic             select_out_six_n_o,
  output logic             select_out_seven_n_o
);

  // ***************************************************************
  // carrier to the window comparator
  // ***************************************************************
  csd_if link ();

  // one register per pin keeps each output a plain flip-flop
  logic select_out_zero_n_d;
  logic select_out_zero_n_q;
  logic select_out_one_n_d;
  logic select_out_one_n_q;
  logic select_out_two_n_d;
  logic select_out_two_n_q;
  logic select_out_three_n_d;
  logic select_out_three_n_q;
  logic select_out_four_n_d;
  logic select_out_four_n_q;
  logic select_out_five_n_d;
  logic select_out_five_n_q;
  logic select_out_six_n_d;
  logic select_out_six_n_q;
  logic select_out_seven_n_d;
  logic select_out_seven_n_q;

  // ***************************************************************
  // access and area codes into the comparator
  // ***************************************************************
  assign link.addr   = access_addr_i;
  assign link.strobe = access_valid_i;
  assign link.codes  = area_select_code_i;

  // tables for each output live in the package lookup
  csd_cmp u_cmp (
    .bus (link.cmp)
  );

  // ***************************************************************
  // select output zero
  // ***************************************************************
  // enable low holds the last decode; one cycle latency from the access
  always_comb
  begin
    select_out_zero_n_d = select_out_zero_n_q;
    if (clk_en_i)
    begin
      select_out_zero_n_d = ~link.hit[0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      select_out_zero_n_q <= SEL_RESET[0];
    end
    else
    begin
      select_out_zero_n_q <= select_out_zero_n_d;
    end
  end

  // ***************************************************************
  // select output one
  // ***************************************************************
  always_comb
  begin
    select_out_one_n_d = select_out_one_n_q;
    if (clk_en_i)
    begin
      select_out_one_n_d = ~link.hit[1];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      select_out_one_n_q <= SEL_RESET[1];
    end
    else
    begin
      select_out_one_n_q <= select_out_one_n_d;
    end
  end

  // ***************************************************************
  // select output two
  // ***************************************************************
  always_comb
  begin
    select_out_two_n_d = select_out_two_n_q;
    if (clk_en_i)
    begin
      select_out_two_n_d = ~link.hit[2];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      select_out_two_n_q <= SEL_RESET[2];
    end
    else
    begin
      select_out_two_n_q <= select_out_two_n_d;
    end
  end

  // ***************************************************************
  // select output three
  // ***************************************************************
  always_comb
  begin
    select_out_three_n_d = select_out_three_n_q;
    if (clk_en_i)
    begin
      select_out_three_n_d = ~link.hit[3];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      select_out_three_n_q <= SEL_RESET[3];
    end
    else
    begin
      select_out_three_n_q <= select_out_three_n_d;
    end
  end

  // ***************************************************************
  // select output four
  // ***************************************************************
  always_comb
  begin
    select_out_four_n_d = select_out_four_n_q;
    if (clk_en_i)
    begin
      select_out_four_n_d = ~link.hit[4];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      select_out_four_n_q <= SEL_RESET[4];
    end
    else
    begin
      select_out_four_n_q <= select_out_four_n_d;
    end
  end

  // ***************************************************************
  // select output five
  // ***************************************************************
  always_comb
  begin
    select_out_five_n_d = select_out_five_n_q;
    if (clk_en_i)
    begin
      select_out_five_n_d = ~link.hit[5];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      select_out_five_n_q <= SEL_RESET[5];
    end
    else
    begin
      select_out_five_n_q <= select_out_five_n_d;
    end
  end

  // ***************************************************************
  // select output six
  // ***************************************************************
  always_comb
  begin
    select_out_six_n_d = select_out_six_n_q;
    if (clk_en_i)
    begin
      select_out_six_n_d = ~link.hit[6];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      select_out_six_n_q <= SEL_RESET[6];
    end
    else
    begin
      select_out_six_n_q <= select_out_six_n_d;
    end
  end

  // ***************************************************************
  // select output seven
  // ***************************************************************
  always_comb
  begin
    select_out_seven_n_d = select_out_seven_n_q;
    if (clk_en_i)
    begin
      select_out_seven_n_d = ~link.hit[7];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      select_out_seven_n_q <= SEL_RESET[7];
    end
    else
    begin
      select_out_seven_n_q <= select_out_seven_n_d;
    end
  end

  // ***************************************************************
  // pins
  // ***************************************************************
  assign select_out_zero_n_o  = select_out_zero_n_q;
  assign select_out_one_n_o   = select_out_one_n_q;
  assign select_out_two_n_o   = select_out_two_n_q;
  assign select_out_three_n_o = select_out_three_n_q;
  assign select_out_four_n_o  = select_out_four_n_q;
  assign select_out_five_n_o  = select_out_five_n_q;
  assign select_out_six_n_o   = select_out_six_n_q;
  assign select_out_seven_n_o = select_out_seven_n_q;

endmodule

// *** bench/csd_top_monitor.sv ***
// pin assertions for the select decoder, bound onto csd_top below
// assumes registered active-low selects, one cycle behind the access
`timescale 1ns/1ps
module csd_top_monitor (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        clk_en_i,
  input wire logic [23:0] access_addr_i,
  input wire logic        access_valid_i,
  input wire logic [15:0] area_select_code_i,
  input wire logic        select_out_zero_n_o,
  input wire logic        select_out_seven_n_o);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic [23:0] a = access_addr_i;
  wire logic [3:0]  c = {area_select_code_i[15:14], area_select_code_i[1:0]};
  wire logic        g = clk_en_i && access_valid_i;
  wire logic [1:0]  s = {select_out_seven_n_o, select_out_zero_n_o};
  a_first_idle: assert property (!$past(rst_n_i) |-> &s) else $error("select after reset");
  a_idle_off: assert property (clk_en_i && !access_valid_i |=> &s) else $error("idle select");
  a_freeze_hold: assert property (!clk_en_i |=> $stable(s)) else $error("select moved");
  a_zero_rsvd: assert property (clk_en_i && c[1:0] == 2'h3 |=> s[0]) else $error("s0 rsvd");
  a_seven_rsvd: assert property (clk_en_i && c[3:2] == 2'h3 |=> s[1]) else $error("s7 rsvd");
  a_zero_rom: assert property (g && !c[1:0] && &a[23:20] |=> !s[0]) else $error("s0 off");
  a_zero_miss: assert property (g && c[1:0] == 2'h1 && ~&a[23:19] |=> s[0]) else $error("s0");
  a_seven_hit: assert property (g && c[3:2] == 2'h2 && a[23:3] == 21'h19 |=> !s[1])
    else $error("s7 off");
  cover property (g && !c[1:0] ##1 !s[0]);
  cover property (!clk_en_i ##1 clk_en_i);
  cover property (g && c[3:2] == 2'h2 ##1 !s[1]);
endmodule
bind csd_top csd_top_monitor u_mon (.*);

// *** bench/csd_ext_dev.sv ***
// counts the external devices selected, one for each active-low select that is low
// assumes the eight selects arrive straight from the decoder pins
`timescale 1ns/1ps
module csd_ext_dev (
  input  wire logic [7:0] sel_n_i,
  output logic      [3:0] n_sel_o);
  assign n_sel_o = 4'($countones(~sel_n_i));
endmodule

// *** bench/testbench.sv ***
// random windows plus edges just outside them; registered selects, one cycle late
// assumes the decoder samples on the rising edge and the bench drives on the falling one
`timescale 1ns/1ps
module testbench;
  localparam bit [31:0] W [32] = '{'hf0000014, 'hf8000013, 'hfe000011, 0, 'he0000015,
    'hf0000013, 'hfc000011, 'h68ff8007, 'h0030000c, 'hfa000011, 'h68ff8007, 'h68ff0007,
    'hf8000011, 'h68ff0007, 'h68fe8007, 'hc006, 'h0028000b, 'h68fe8007, 'hc006, 'he005,
    'h68ff8007, 'hc006, 'he005, 'hd803, 'h68ff0007, 'hc006, 'he005, 'hd003, 'hc006, 'he005, 'hc803, 0};
  logic clk = 0, rst_n = 0, en = 0, v = 0;
  logic [31:0] r, a = 0;
  logic [15:0] c = 0;
  logic [7:0] e = 8'hff, s;
  logic [3:0] n_act;
  int error_cnt = 0, n_compared = 0;
  csd_top dut (.ref_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(en), .access_addr_i(a[23:0]),
    .access_valid_i(v), .area_select_code_i(c), .select_out_zero_n_o(s[0]),
    .select_out_one_n_o(s[1]), .select_out_two_n_o(s[2]), .select_out_three_n_o(s[3]),
    .select_out_four_n_o(s[4]), .select_out_five_n_o(s[5]), .select_out_six_n_o(s[6]),
    .select_out_seven_n_o(s[7]));
  csd_ext_dev ext (.sel_n_i(s), .n_sel_o(n_act));
  always #5 clk = ~clk;
  // windows are size-aligned, so a shifted compare is enough
  function automatic bit hit(bit [31:0] w, logic [23:0] x);
    return w != 0 && x >> w[7:0] == w[31:8] >> w[7:0];
  endfunction
  task automatic cmp(logic [7:0] g, logic [7:0] x);
    n_compared++;
    error_cnt += int'(g !== x);
    if (g !== x) $display("mismatch at %0t got %h expected %h", $time, g, x);
  endtask
  task automatic cmp_count(logic [3:0] g, logic [3:0] x);
    n_compared++;
    error_cnt += int'(g !== x);
    if (g !== x) $display("mismatch at %0t got %h expected %h", $time, g, x);
  endtask
  task automatic complete_run(int hang);
    error_cnt += hang;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (!error_cnt && n_compared)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'hbdff));
    rst_n = #40 1'b1;
    for (int k = 0; k < 3000; k++)
    begin
      @(negedge clk);
      cmp(s, e);
      cmp_count(n_act, 4'($countones(~e)));
      r = W[$urandom_range(31)];
      a = r[31:8] + ($urandom & ((2 << r[7:0]) - 1)) - ($urandom_range(3) == 0);
      {c, v, en} = {16'($urandom), |3'($urandom), |3'($urandom)};
      // corners first: lowest and highest address of every entry, all pins on one code
      if (k < 64)
      begin
        r = W[k / 2];
        a = r[31:8] + ((k % 2) ? (1 << r[7:0]) - 1 : 0);
        c = {8{2'(k / 2)}};
        v = 1'b1;
        en = 1'b1;
      end
      for (int i = 0; i < 8; i++) if (en) e[i] = !(v && hit(W[i*4+c[2*i+:2]], a[23:0]));
    end
    complete_run(0);
  end
  initial #40000 complete_run(1);
endmodule
